// ---- rtl/pfrw_params.svh ----
// Register map, field positions, reset values and codes of the row writer.
`ifndef PFRW_PARAMS_SVH
`define PFRW_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PFRW_OFF_ADDR     12'h000
`define PFRW_OFF_DATA     12'h004
`define PFRW_OFF_CTRL     12'h008
`define PFRW_OFF_UNLOCK   12'h00c
`define PFRW_OFF_IRQ      12'h010

// ----------------------------------------------------------------------
// Control and interrupt register fields
// ----------------------------------------------------------------------
`define PFRW_CTRL_RD      0
`define PFRW_CTRL_WR      1
`define PFRW_CTRL_WEN     2
`define PFRW_CTRL_WERR    3
`define PFRW_CTRL_ERASE   4
`define PFRW_CTRL_LATCH_ONLY_SELECT    5
`define PFRW_CTRL_REGS    6
`define PFRW_IRQ_FLAG     0
`define PFRW_IRQ_EN       1

// ----------------------------------------------------------------------
// Codes, sizes and reset values
// ----------------------------------------------------------------------
`define PFRW_UNLOCK_1     8'h55
`define PFRW_UNLOCK_2     8'haa
`define PFRW_BLANK        14'h3fff
`define PFRW_ROW_WORDS    32
`define PFRW_LAST_IDX     5'h1f
`define PFRW_ADDR_RST     16'h0000
`define PFRW_DATA_RST     14'h0000

// ----------------------------------------------------------------------
// Region-select address windows
// ----------------------------------------------------------------------
`define PFRW_UID_LO       16'h8000
`define PFRW_UID_HI       16'h8003
`define PFRW_DID_LO       16'h8005
`define PFRW_DID_HI       16'h8006
`define PFRW_CFG_LO       16'h8007
`define PFRW_CFG_HI       16'h800b
`define PFRW_DIA_LO       16'h8100
`define PFRW_DIA_HI       16'h82ff
`define PFRW_EE_LO        16'hf000
`define PFRW_EE_HI        16'hf0ff

`endif

// ---- rtl/pfrw_latch_mem.sv ----
// Row write latches: 32 words, registered read, one-cycle blank of all.
`timescale 1ns/10ps
`include "pfrw_params.svh"

module pfrw_latch_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Load port
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [13:0] wr_data,
  input  wire logic        blank,
  // Read port
  input  wire logic [4:0]  rd_idx,
  output logic      [13:0] rd_data
);

  logic [13:0] mem_reg [`PFRW_ROW_WORDS];

  // The blank wins over a load; both never come in one cycle anyway.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PFRW_ROW_WORDS; i++) begin
        mem_reg[i] <= `PFRW_BLANK;
      end
    end else if (blank) begin
      for (int i = 0; i < `PFRW_ROW_WORDS; i++) begin
        mem_reg[i] <= `PFRW_BLANK;
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `PFRW_BLANK;
    end else begin
      rd_data <= mem_reg[rd_idx];
    end
  end

endmodule

// ---- rtl/pfrw_unlock.sv ----
// Unlock sequence tracker: 55h, AAh, then the write bit, back to back.
`timescale 1ns/10ps
`include "pfrw_params.svh"

module pfrw_unlock (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Accepted bus access
  input  wire logic       acc,
  input  wire logic       is_unlock_wr,
  input  wire logic [7:0] code,
  input  wire logic       is_start,
  // Result
  output logic            go,
  output logic            broken
);

  logic [1:0] stage_reg;
  logic [1:0] stage_next;
  wire        first_ok  = is_unlock_wr && (code == `PFRW_UNLOCK_1);
  wire        second_ok = is_unlock_wr && (code == `PFRW_UNLOCK_2);

  // Any access between the steps counts as an interruption.
  always_comb begin
    stage_next = stage_reg;
    go         = 1'b0;
    broken     = 1'b0;
    if (acc) begin
      case (stage_reg)
        2'd0: begin
          if (first_ok) begin
            stage_next = 2'd1;
          end else if (is_start) begin
            broken = 1'b1; // RL8
          end
        end
        2'd1: begin
          stage_next = second_ok ? 2'd2 : 2'd0; // RL18
          broken     = !second_ok; // RL21
        end
        default: begin
          stage_next = 2'd0;
          go         = is_start; // RL18
          broken     = !is_start; // RL21
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_reg <= 2'd0;
    end else begin
      stage_reg <= stage_next;
    end
  end

endmodule

// ---- rtl/pfrw_top.sv ----
// Program flash row writer: APB registers, unlock, latches, array walk.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "pfrw_params.svh"

package pfrw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_ERASE,
    ST_FETCH,
    ST_PROG,
    ST_DONE
  } pfrw_state_e;
endpackage

// What this block does
// RL1: Address bits 14:5 pick the row, bits 4:0 pick the latch.
// RL2: A commit touches only the addressed row, never a neighbour.
// RL3: After each program or erase all latches return to 3FFFh.
// RL4: Programming does not erase the row first.
// RL5: Latch-only action copies data to one latch, ignores protection.
// RL6: Commit programs latches to the row; protected row flags error.
// RL7: Erase clears the whole 32-word row; protected row flags error.
// RL8: Without an unbroken unlock no load or array write starts.
// RL9: Error flag sets on protected target, reset mid-write, broken unlock.
// RL10: Software may set the error flag; only software clears it.
// RL11: One commit programs at most the 32 latch words.
// RL12: Software loads latches with latch-only set, then commits.
// RL13: Region select maps ID, config and information at bit 15.
// RL14: Region select allows writes to IDs, config, EEPROM only. The code allows writes to the user ID window but not to the device ID window.
// RL15: Region read outside valid windows clears the data pair.
// RL16: Software rewrites a row via RAM image, erase and reload.
// RL17: Software should read back and compare after the commit.
// RL18: Unlock is 55h, AAh, then the write bit, in that order.
// RL19: The bus stalls while an array action runs.
// RL20: Completion sets a flag; enabled flag raises the interrupt.
// RL21: Any access breaking the unlock order aborts and flags error.
module pfrw_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Power-on reset, survives system reset
  input  wire logic        por_n,
  // Protection status from configuration
  input  wire logic        write_protect,
  // Flash array port
  output logic             flash_rd,
  output logic             flash_prog,
  output logic             flash_erase,
  output logic             flash_region,
  output logic      [15:0] flash_addr,
  output logic      [13:0] flash_wdata,
  input  wire logic [13:0] flash_rdata,
  input  wire logic        flash_done,
  // Status
  output logic             cpu_stall,
  output logic             completion_irq
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  pfrw_pkg::pfrw_state_e state_reg;
  pfrw_pkg::pfrw_state_e state_next;
  logic [15:0] nvm_address_reg;
  logic [13:0] nvm_data_reg;
  logic        rd_reg;
  logic        wr_reg;
  logic        write_enable_gate_reg;
  logic        write_error_flag_reg;
  logic        erase_select_reg;
  logic        latch_only_select_reg;
  logic        region_select_reg;
  logic        completion_irq_flag_reg;
  logic        completion_irq_enable_reg;
  logic [4:0]  idx_reg;
  logic        in_progress_reg;
  logic        rd_dat_reg;
  logic        prog_out_reg;
  logic        erase_out_reg;
  logic [13:0] wdata_out_reg;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire        busy      = (state_reg != pfrw_pkg::ST_IDLE);
  wire        acc       = psel && penable && pready;
  wire        wacc      = acc && pwrite;
  wire        sel_addr  = (paddr == `PFRW_OFF_ADDR);
  wire        sel_data  = (paddr == `PFRW_OFF_DATA);
  wire        sel_ctrl  = (paddr == `PFRW_OFF_CTRL);
  wire        sel_unl   = (paddr == `PFRW_OFF_UNLOCK);
  wire        sel_irq   = (paddr == `PFRW_OFF_IRQ);
  wire        mapped    = sel_addr || sel_data || sel_ctrl || sel_unl ||
                          sel_irq;
  wire        wr_ctrl   = wacc && sel_ctrl;
  wire        start_req = wr_ctrl && pwdata[`PFRW_CTRL_WR];
  wire        rd_req    = wr_ctrl && pwdata[`PFRW_CTRL_RD] && !busy;
  wire        region_now = wr_ctrl ? pwdata[`PFRW_CTRL_REGS] :
                           region_select_reg;
  wire        go;
  wire        broken;

  // ----------------------------------------------------------------------
  // Target decode
  // ----------------------------------------------------------------------
  wire [15:0] a         = nvm_address_reg;
  wire        in_uid    = (a >= `PFRW_UID_LO) && (a <= `PFRW_UID_HI);
  wire        in_did    = (a >= `PFRW_DID_LO) && (a <= `PFRW_DID_HI);
  wire        in_cfg    = (a >= `PFRW_CFG_LO) && (a <= `PFRW_CFG_HI);
  wire        in_dia    = (a >= `PFRW_DIA_LO) && (a <= `PFRW_DIA_HI);
  wire        in_ee     = (a >= `PFRW_EE_LO) && (a <= `PFRW_EE_HI);
  wire        reg_rd_ok = in_uid || in_did || in_cfg || in_dia || in_ee; // RL15
  wire        reg_wr_ok = in_uid || in_cfg || in_ee; // RL14
  wire        wr_denied = region_select_reg ? !reg_wr_ok : write_protect;
  wire [9:0]  row       = a[14:5]; // RL1
  wire [4:0]  latch_idx = a[4:0]; // RL1

  // ----------------------------------------------------------------------
  // Action decode at the unlock's final step
  // ----------------------------------------------------------------------
  wire        armed     = go && write_enable_gate_reg;
  wire        do_erase  = armed && erase_select_reg && !wr_denied; // RL7
  wire        do_load   = armed && !erase_select_reg &&
                          latch_only_select_reg; // RL5
  wire        do_prog   = armed && !erase_select_reg &&
                          !latch_only_select_reg && !wr_denied; // RL6
  wire        denied    = armed && !(erase_select_reg ||
                          latch_only_select_reg) && wr_denied ||
                          armed && erase_select_reg && wr_denied; // RL9
  wire        finish    = (state_reg == pfrw_pkg::ST_DONE);
  // The latch read is registered, so it is addressed with the next index.
  wire [4:0]  idx_next  = do_prog ? 5'h00 :
                          (state_reg == pfrw_pkg::ST_PROG && flash_done) ?
                          idx_reg + 5'h01 : idx_reg; // RL2
  wire        reset_hit = in_progress_reg && !busy && !finish; // RL9
  wire        err_set   = broken || denied || reset_hit;
  wire [13:0] latch_q;

  pfrw_unlock u_unlock (
    .clk          (pclk),
    .rst_n        (presetn),
    .acc          (acc),
    .is_unlock_wr (wacc && sel_unl),
    .code         (pwdata[7:0]),
    .is_start     (start_req),
    .go           (go),
    .broken       (broken)
  );

  pfrw_latch_mem u_latches (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (do_load),
    .wr_idx  (latch_idx),
    .wr_data (nvm_data_reg),
    .blank   (finish && wr_reg), // RL3
    .rd_idx  (idx_next),
    .rd_data (latch_q)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Programming writes each word as is; the row is never erased first.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pfrw_pkg::ST_IDLE: begin
        if (do_erase) begin
          state_next = pfrw_pkg::ST_ERASE;
        end else if (do_prog) begin
          state_next = pfrw_pkg::ST_FETCH; // RL4
        end else if (rd_req) begin
          state_next = pfrw_pkg::ST_READ;
        end
      end
      pfrw_pkg::ST_READ: begin
        if (flash_done || (region_select_reg && !reg_rd_ok)) begin
          state_next = pfrw_pkg::ST_IDLE;
        end
      end
      pfrw_pkg::ST_ERASE: begin
        if (flash_done) begin
          state_next = pfrw_pkg::ST_DONE;
        end
      end
      pfrw_pkg::ST_FETCH: begin
        state_next = pfrw_pkg::ST_PROG;
      end
      pfrw_pkg::ST_PROG: begin
        if (flash_done) begin
          state_next = (idx_reg == `PFRW_LAST_IDX) ?
                       pfrw_pkg::ST_DONE : pfrw_pkg::ST_FETCH; // RL11
        end
      end
      default: begin
        state_next = pfrw_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pfrw_pkg::ST_IDLE;
      idx_reg   <= 5'h00;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
    end
  end

  // ----------------------------------------------------------------------
  // Array strobes; a strobe holds until the array reports done.
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_out_reg  <= 1'b0;
      erase_out_reg <= 1'b0;
      rd_dat_reg    <= 1'b0;
      wdata_out_reg <= `PFRW_BLANK;
    end else begin
      prog_out_reg  <= (state_next == pfrw_pkg::ST_PROG);
      erase_out_reg <= (state_next == pfrw_pkg::ST_ERASE);
      rd_dat_reg    <= (state_next == pfrw_pkg::ST_READ) &&
                       !(region_now && !reg_rd_ok);
      if (state_reg == pfrw_pkg::ST_FETCH) begin
        wdata_out_reg <= latch_q;
      end
    end
  end

  // Row bits come from the address; the word bits come from the walk while programming, else from the address.
  assign flash_rd     = rd_dat_reg;
  assign flash_prog   = prog_out_reg;
  assign flash_erase  = erase_out_reg; // RL7
  assign flash_region = region_select_reg; // RL13
  assign flash_addr   = (state_reg == pfrw_pkg::ST_PROG) ?
                        {a[15], row, idx_reg} : {a[15], row, latch_idx}; // RL2
  assign flash_wdata  = wdata_out_reg;
  assign cpu_stall    = busy; // RL19
  assign pready       = !busy; // RL19
  assign pslverr      = psel && penable && !mapped;
  assign completion_irq = completion_irq_flag_reg &&
                          completion_irq_enable_reg; // RL20

  // ----------------------------------------------------------------------
  // Address and data registers
  // ----------------------------------------------------------------------
  // A region read outside the windows clears the data pair.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_address_reg <= `PFRW_ADDR_RST;
      nvm_data_reg    <= `PFRW_DATA_RST;
    end else begin
      if (wacc && sel_addr) begin
        nvm_address_reg <= pwdata[15:0];
      end
      if (state_reg == pfrw_pkg::ST_READ && region_select_reg &&
          !reg_rd_ok) begin
        nvm_data_reg <= `PFRW_DATA_RST; // RL15
      end else if (state_reg == pfrw_pkg::ST_READ && flash_done) begin
        nvm_data_reg <= flash_rdata;
      end else if (wacc && sel_data) begin
        nvm_data_reg <= pwdata[13:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // The write bit is set only through the unlock and cleared by hardware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_reg                <= 1'b0;
      wr_reg                <= 1'b0;
      write_enable_gate_reg <= 1'b0;
      erase_select_reg      <= 1'b0;
      latch_only_select_reg <= 1'b0;
      region_select_reg     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        write_enable_gate_reg <= pwdata[`PFRW_CTRL_WEN];
        erase_select_reg      <= pwdata[`PFRW_CTRL_ERASE];
        latch_only_select_reg <= pwdata[`PFRW_CTRL_LATCH_ONLY_SELECT];
        region_select_reg     <= pwdata[`PFRW_CTRL_REGS];
      end
      if (rd_req) begin
        rd_reg <= 1'b1;
      end else if (state_reg == pfrw_pkg::ST_READ &&
                   state_next == pfrw_pkg::ST_IDLE) begin
        rd_reg <= 1'b0;
      end
      if (do_erase || do_prog) begin
        wr_reg <= 1'b1;
      end else if (finish) begin
        wr_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Error flag and self-write marker, kept across system reset
  // ----------------------------------------------------------------------
  // Only the power-on reset clears these, so a system reset that lands in
  // the middle of a self-write is still seen on the first clock after it.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      write_error_flag_reg <= 1'b0;
      in_progress_reg      <= 1'b0;
    end else begin
      in_progress_reg <= busy && (state_reg != pfrw_pkg::ST_READ) &&
                         !finish;
      if (err_set) begin
        write_error_flag_reg <= 1'b1; // RL9
      end else if (wr_ctrl) begin
        write_error_flag_reg <= pwdata[`PFRW_CTRL_WERR]; // RL10
      end
    end
  end

  // ----------------------------------------------------------------------
  // Completion flag and enable
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      completion_irq_flag_reg   <= 1'b0;
      completion_irq_enable_reg <= 1'b0;
    end else begin
      if (finish) begin
        completion_irq_flag_reg <= 1'b1; // RL20
      end else if (wacc && sel_irq) begin
        completion_irq_flag_reg <= pwdata[`PFRW_IRQ_FLAG];
      end
      if (wacc && sel_irq) begin
        completion_irq_enable_reg <= pwdata[`PFRW_IRQ_EN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read mux; blanking after every finish is done in the latch module.
  // ----------------------------------------------------------------------
  wire [31:0] ctrl_word = {25'h0000000, region_select_reg,
                           latch_only_select_reg, erase_select_reg,
                           write_error_flag_reg, write_enable_gate_reg,
                           wr_reg, rd_reg};
  wire [31:0] irq_word  = {30'h00000000, completion_irq_enable_reg,
                           completion_irq_flag_reg};
  wire [31:0] rd_word   = sel_addr ? {16'h0000, nvm_address_reg} :
                          sel_data ? {18'h00000, nvm_data_reg} :
                          sel_ctrl ? ctrl_word :
                          sel_irq  ? irq_word : 32'h00000000;

  assign prdata = (psel && !pwrite) ? rd_word : 32'h00000000;

endmodule

// ---- tb/pfrw_monitor.sv ----
// Port checker of the program flash row writer.
`timescale 1ns/10ps
`include "pfrw_params.svh"

module pfrw_monitor (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Array side and status
  input wire logic        flash_rd,
  input wire logic        flash_prog,
  input wire logic        flash_erase,
  input wire logic        flash_region,
  input wire logic [15:0] flash_addr,
  input wire logic        flash_done,
  input wire logic        cpu_stall,
  input wire logic        completion_irq
);
  logic [5:0] n_done;

  // Counts finished program steps; the count restarts whenever the stall is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_done <= 6'h00;
    end else if (!cpu_stall) begin
      n_done <= 6'h00;
    end else if (flash_prog && flash_done) begin
      n_done <= n_done + 6'h01;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  stall_level_a: assert property (
    (flash_rd || flash_prog || flash_erase) |-> cpu_stall && !pready)
    else $error("array step without stall");
  one_strobe_a: assert property (
    $onehot0({flash_rd, flash_prog, flash_erase}))
    else $error("two array strobes at once");
  hold_step_a: assert property (
    (flash_prog || flash_erase) && !flash_done
    |=> $stable({flash_prog, flash_erase, flash_addr}))
    else $error("array step changed before done");
  word_order_a: assert property (
    flash_prog && flash_done |-> flash_addr[4:0] == n_done[4:0])
    else $error("program word out of order");
  prog_count_a: assert property (
    n_done <= 6'h20)
    else $error("more than one row of words");
  region_read_a: assert property (
    flash_rd && flash_region |-> flash_addr[15])
    else $error("region read outside mapped space");
  erase_start_a: assert property (
    $rose(flash_erase) |-> $past(psel && penable && pwrite
    && paddr == `PFRW_OFF_CTRL && pwdata[`PFRW_CTRL_ERASE]))
    else $error("erase without control write");
  erase_end_a: assert property (
    flash_erase && flash_done |=> !flash_erase ##1 pready)
    else $error("erase end timing wrong");
  irq_cause_a: assert property (
    $rose(completion_irq) |-> $past(flash_done, 2)
    || $past(psel && penable && pwrite && paddr == `PFRW_OFF_IRQ))
    else $error("interrupt without cause");

  cover property (flash_erase && flash_done);
  cover property (flash_prog && flash_done && flash_addr[4:0] == 5'h1f);
  cover property (flash_rd && flash_region);
endmodule

bind pfrw_top pfrw_monitor mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .flash_rd, .flash_prog,
  .flash_erase, .flash_region, .flash_addr, .flash_done, .cpu_stall,
  .completion_irq);

// ---- tb/pfrw_top_tb.sv ----
// Self-checking bench of the row writer over APB.
`timescale 1ns/10ps
`include "pfrw_params.svh"

module pfrw_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        por_n, write_protect, err, flash_rd, flash_prog;
  logic        flash_erase, flash_region, flash_done, cpu_stall;
  logic        completion_irq, hold;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] flash_addr;
  logic [13:0] flash_wdata, flash_rdata;
  logic [13:0] img [32];
  int          fails, num_checks, n_prog, n_erase, bad_row;

  pfrw_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .por_n, .write_protect,
    .flash_rd, .flash_prog, .flash_erase, .flash_region, .flash_addr,
    .flash_wdata, .flash_rdata, .flash_done, .cpu_stall,
    .completion_irq);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Array model and tasks
  // ------------------------------------------------------------
  // The array ends each step one cycle after its strobe is seen.
  // Hold keeps a step running so that a reset can land inside it.
  always @(posedge pclk) begin
    flash_done <= (flash_rd || flash_prog || flash_erase) && !flash_done &&
                  !hold;
    if ((flash_prog || flash_erase) && flash_done) begin
      if (flash_addr[14:5] !== 10'h002) bad_row++;
      if (flash_erase) n_erase++;
      if (flash_prog) n_prog++;
      if (flash_prog) img[flash_addr[4:0]] <= flash_wdata;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pready is sampled at the rising edge at which the design takes it.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 5000) begin
      fails++;
      summarize();
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                     input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // The action bits and the gate must stand before the sequence starts.
  task automatic unlock(input logic [31:0] ctrl);
    apb(1'b1, `PFRW_OFF_CTRL, ctrl);
    apb(1'b1, `PFRW_OFF_UNLOCK, 32'(`PFRW_UNLOCK_1));
    apb(1'b1, `PFRW_OFF_UNLOCK, 32'(`PFRW_UNLOCK_2));
    apb(1'b1, `PFRW_OFF_CTRL, ctrl | 32'h2);
  endtask

  task automatic check_row(input logic [13:0] w3, w31);
    for (int i = 0; i < 32; i++) begin
      chk("row word", 32'((i == 3) ? w3 : (i == 31) ? w31 : 14'h3fff),
          32'(img[i]));
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, por_n, psel, penable, pwrite, write_protect, hold} = 7'h00;
    {paddr, pwdata, flash_done} = 45'h0;
    flash_rdata = 14'h15a5;
    {fails, num_checks, n_prog, n_erase, bad_row} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rdc(`PFRW_OFF_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
    apb(1'b1, `PFRW_OFF_ADDR, 32'h0045);
    unlock(32'h14);
    rdc(`PFRW_OFF_IRQ, 32'h1, "irq flag");
    chk("erase steps", 32'h1, 32'(n_erase));
    $display("test erase done");
    apb(1'b1, `PFRW_OFF_ADDR, 32'h0043);
    apb(1'b1, `PFRW_OFF_DATA, 32'h1234);
    unlock(32'h24);
    apb(1'b1, `PFRW_OFF_ADDR, 32'h005f);
    apb(1'b1, `PFRW_OFF_DATA, 32'h0abc);
    unlock(32'h24);
    chk("load no access", 32'h0, 32'(n_prog));
    apb(1'b1, `PFRW_OFF_DATA, 32'h0777);
    unlock(32'h04);
    rdc(`PFRW_OFF_CTRL, 32'h04, "ctrl after commit");
    chk("program steps", 32'h20, 32'(n_prog));
    check_row(14'h1234, 14'h0abc);
    unlock(32'h04);
    rdc(`PFRW_OFF_CTRL, 32'h04, "ctrl after commit");
    check_row(14'h3fff, 14'h3fff);
    chk("row kept", 32'h0, 32'(bad_row));
    $display("test program done");
    write_protect <= 1'b1;
    unlock(32'h14);
    rdc(`PFRW_OFF_CTRL, 32'h1c, "protected erase");
    chk("erase steps", 32'h1, 32'(n_erase));
    write_protect <= 1'b0;
    apb(1'b1, `PFRW_OFF_CTRL, 32'h0);
    rdc(`PFRW_OFF_CTRL, 32'h0, "error cleared");
    apb(1'b1, `PFRW_OFF_CTRL, 32'h08);
    rdc(`PFRW_OFF_CTRL, 32'h08, "error set");
    apb(1'b1, `PFRW_OFF_CTRL, 32'h14);
    apb(1'b1, `PFRW_OFF_UNLOCK, 32'h55);
    rdc(`PFRW_OFF_ADDR, 32'h5f, "address");
    apb(1'b1, `PFRW_OFF_UNLOCK, 32'haa);
    apb(1'b1, `PFRW_OFF_CTRL, 32'h16);
    rdc(`PFRW_OFF_CTRL, 32'h1c, "broken unlock");
    chk("erase steps", 32'h1, 32'(n_erase));
    $display("test protect done");
    hold <= 1'b1;
    unlock(32'h14);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    hold <= 1'b0;
    rdc(`PFRW_OFF_CTRL, 32'h08, "reset mid erase");
    $display("test reset hit done");
    apb(1'b1, `PFRW_OFF_DATA, 32'h0321);
    apb(1'b1, `PFRW_OFF_ADDR, 32'h8004);
    apb(1'b1, `PFRW_OFF_CTRL, 32'h41);
    rdc(`PFRW_OFF_DATA, 32'h0, "gap read");
    apb(1'b1, `PFRW_OFF_ADDR, 32'h8005);
    apb(1'b1, `PFRW_OFF_CTRL, 32'h41);
    rdc(`PFRW_OFF_DATA, 32'h15a5, "id read");
    apb(1'b1, `PFRW_OFF_IRQ, 32'h3);
    @(negedge pclk);
    chk("irq on", 32'h1, {31'h0, completion_irq});
    apb(1'b1, `PFRW_OFF_IRQ, 32'h2);
    @(negedge pclk);
    chk("irq off", 32'h0, {31'h0, completion_irq});
    $display("test region done");
    summarize();
  end
endmodule
